// file: dlop_limit_overrun.sv
// Behaviour
// - limit inputs ignored by default; handled only with selection 0 or 2
// - stop select 0/1: dynamic brake or free-run, clear counter; then zero torque, hold
// - stop select 2: controlled stop, hold counter; then clear once, then hold
// - selection 2: any active limit raises alarm 38.0; alarm stop select governs
// - deceleration ends when speed first reaches 30 r/min or below
// - stop-2 deceleration torque limit from estop setting; 0 selects normal limit
// - warning 95 on command into active limit direction while stopped
// - forward limit off blocks forward only; reverse limit off blocks reverse only
// - selection 1 with monitor select 1 shows limits on monitor, else hidden
// - alarm 34.0 when motor position leaves widened command range
// - overrun check only in position or full-closing mode, servo-on
// - command range cleared on reset, error clear, trial edges, speed/torque, init
// - after overrun, stop by alarm stop selection
// - overrun check disabled when frequency characteristic function enabled
// - range is start position plus overrun setting each side, extended by commands
// - selection 1 disables both limit inputs
// - selection 0 raises alarm 38.0 when both limit inputs open
`timescale 1ns/1ps
`default_nettype none
`include "dlop_map.svh"

module dlop_limit_overrun (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic forward_limit_input,
    input wire logic reverse_limit_input,
    output dlop_pkg::dlop_drive_type drive,
    output logic [9:0] torque_limit,
    output logic alarm_stop,
    output logic mon_fwd,
    output logic mon_rev,
    output logic irq
);
    import dlop_pkg::*;

    // pin synchronisers (limit inputs are 1 when the switch is shorted, i.e. normal)
    logic [1:0] fwd_sync_ff;
    logic [1:0] rev_sync_ff;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fwd_sync_ff <= 2'h3;
            rev_sync_ff <= 2'h3;
        end
        else
        begin
            fwd_sync_ff <= {fwd_sync_ff[0], forward_limit_input};
            rev_sync_ff <= {rev_sync_ff[0], reverse_limit_input};
        end
    end
    logic fwd_open;
    logic rev_open;
    assign fwd_open = !fwd_sync_ff[1];
    assign rev_open = !rev_sync_ff[1];

    // registers
    logic [7:0] ctrl_ff;
    logic [7:0] limsel_ff;
    logic [9:0] etq_ff;
    logic [31:0] ovr_ff;
    logic signed [31:0] cmd_ff;
    logic signed [31:0] mpos_ff;
    logic [15:0] speed_ff;
    logic [2:0] irq_ff;
    logic [2:0] mask_ff;
    logic [9:0] norm_tlim_ff;
    logic signed [31:0] lo_ff;
    logic signed [31:0] hi_ff;
    logic signed [31:0] base_ff;
    logic cmd_pulse_ff;
    logic alm38_ff;
    logic alm34_ff;
    logic trial_d_ff;
    dlop_phase_type phase_ff;
    dlop_phase_type nxt_phase;

    logic [1:0] lim_sel;
    logic [1:0] stop_sel;
    logic [1:0] alm_sel;
    logic servo_on;
    dlop_mode_type mode;
    assign lim_sel = limsel_ff[`DLOP_LIM_SEL_LO +: 2];
    assign stop_sel = limsel_ff[`DLOP_STOP_SEL_LO +: 2];
    assign alm_sel = limsel_ff[`DLOP_ALM_STOP_LO +: 2];
    assign servo_on = ctrl_ff[`DLOP_CTRL_SERVO_ON];
    assign mode = dlop_mode_type'(ctrl_ff[`DLOP_CTRL_MODE_LO +: 2]);

    // AHB address phase capture
    logic wr_ff;
    logic rd_ff;
    logic [7:0] addr_ff;
    logic acc;
    assign acc = hsel && hready && htrans[1];
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
            addr_ff <= 8'h00;
        end
        else
        begin
            wr_ff <= acc && hwrite;
            rd_ff <= acc && !hwrite;
            addr_ff <= haddr[7:0];
        end
    end

    logic wr_ctrl;
    logic wr_cmd;
    assign wr_ctrl = wr_ff && addr_ff == `DLOP_CTRL_OFS;
    assign wr_cmd = wr_ff && addr_ff == `DLOP_CMD_OFS;

    // stop state and limit enables
    logic lim_en;
    logic fwd_act;
    logic rev_act;
    logic stopped_now;
    assign lim_en = lim_sel == 2'd0 || lim_sel == 2'd2;
    assign fwd_act = lim_en && fwd_open;
    assign rev_act = lim_en && rev_open;
    assign stopped_now = speed_ff <= `DLOP_STOP_SPEED;

    logic alarm_any;
    assign alarm_any = alm38_ff || alm34_ff;

    always_comb
    begin
        nxt_phase = phase_ff;
        unique case (phase_ff)
            DLOP_RUN:
                if ((fwd_act || rev_act) && !alarm_any)
                    nxt_phase = stopped_now ? DLOP_STOPPED : DLOP_DECEL;
            DLOP_DECEL:
                if (!fwd_act && !rev_act)
                    nxt_phase = DLOP_RUN;
                else if (stopped_now)
                    nxt_phase = DLOP_STOPPED;
            DLOP_STOPPED:
                if (!fwd_act && !rev_act)
                    nxt_phase = DLOP_RUN;
            default:
                nxt_phase = DLOP_RUN;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            phase_ff <= DLOP_RUN;
        else
            phase_ff <= nxt_phase;
    end

    // error counter clear events
    logic decel_clear;
    logic estop_done_clear;
    logic err_clear;
    assign decel_clear = phase_ff == DLOP_DECEL && stop_sel != 2'd2;
    assign estop_done_clear = phase_ff == DLOP_DECEL && nxt_phase == DLOP_STOPPED
        && stop_sel == 2'd2;
    assign err_clear = decel_clear || estop_done_clear || !servo_on
        || (wr_ctrl && hwdata[`DLOP_CTRL_ERR_CLR]);

    // alarms
    logic a38_set;
    logic w95_set;
    logic a34_set;
    logic ovr_en;
    assign a38_set = (lim_sel == 2'd2 && (fwd_open || rev_open))
        || (lim_sel == 2'd0 && fwd_open && rev_open);
    assign ovr_en = (mode == DLOP_MODE_POS || mode == DLOP_MODE_FULL) && servo_on
        && !ctrl_ff[`DLOP_CTRL_FREQ_CHAR];
    assign a34_set = ovr_en && (mpos_ff < lo_ff || mpos_ff > hi_ff);
    assign w95_set = cmd_pulse_ff && stopped_now
        && ((fwd_act && !cmd_ff[31] && cmd_ff != 32'h0)
        || (rev_act && cmd_ff[31]));

    logic alm_rst;
    assign alm_rst = wr_ctrl && hwdata[`DLOP_CTRL_ALM_RST];
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            alm38_ff <= 1'b0;
            alm34_ff <= 1'b0;
        end
        else
        begin
            alm38_ff <= a38_set || (alm38_ff && !alm_rst);
            alm34_ff <= a34_set || (alm34_ff && !alm_rst);
        end
    end

    // command range: clear conditions, then extend with each command
    logic trial_edge;
    logic range_clr;
    assign trial_edge = ctrl_ff[`DLOP_CTRL_TRIAL] != trial_d_ff;
    assign range_clr = err_clear || trial_edge
        || mode == DLOP_MODE_SPD || mode == DLOP_MODE_TRQ
        || (wr_ctrl && hwdata[`DLOP_CTRL_POS_INIT]);
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            lo_ff <= 32'sh0;
            hi_ff <= 32'sh0;
            base_ff <= 32'sh0;
            trial_d_ff <= 1'b0;
        end
        else
        begin
            trial_d_ff <= ctrl_ff[`DLOP_CTRL_TRIAL];
            if (range_clr)
            begin
                base_ff <= mpos_ff;
                lo_ff <= mpos_ff - $signed(ovr_ff);
                hi_ff <= mpos_ff + $signed(ovr_ff);
            end
            else if (cmd_pulse_ff)
            begin
                base_ff <= base_ff + cmd_ff;
                if (cmd_ff[31] && base_ff + cmd_ff - $signed(ovr_ff) < lo_ff)
                    lo_ff <= base_ff + cmd_ff - $signed(ovr_ff);
                if (!cmd_ff[31] && base_ff + cmd_ff + $signed(ovr_ff) > hi_ff)
                    hi_ff <= base_ff + cmd_ff + $signed(ovr_ff);
            end
        end
    end

    // register writes
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_ff <= 8'h00;
            limsel_ff <= `DLOP_LIMSEL_RST;
            etq_ff <= `DLOP_ETQ_RST;
            ovr_ff <= `DLOP_OVR_RST;
            cmd_ff <= 32'sh0;
            mpos_ff <= 32'sh0;
            speed_ff <= 16'h0000;
            norm_tlim_ff <= `DLOP_TLIM_RST;
            cmd_pulse_ff <= 1'b0;
        end
        else
        begin
            cmd_pulse_ff <= wr_cmd;
            if (wr_ctrl)
                ctrl_ff <= {2'b00, hwdata[5], 1'b0, hwdata[3:0]};
            if (wr_ff && addr_ff == `DLOP_LIMSEL_OFS)
                limsel_ff <= hwdata[7:0];
            if (wr_ff && addr_ff == `DLOP_ETQ_OFS)
                etq_ff <= hwdata[9:0] > `DLOP_ETQ_MAX ? `DLOP_ETQ_MAX : hwdata[9:0];
            if (wr_ff && addr_ff == `DLOP_OVR_OFS)
                ovr_ff <= hwdata;
            if (wr_cmd)
                cmd_ff <= hwdata;
            if (wr_ff && addr_ff == `DLOP_MPOS_OFS)
                mpos_ff <= hwdata;
            if (wr_ff && addr_ff == `DLOP_SPEED_OFS)
                speed_ff <= hwdata[15:0];
            if (wr_ff && addr_ff == `DLOP_OUT_OFS)
                norm_tlim_ff <= hwdata[9:0];
        end
    end

    // sticky interrupt status, write one to clear, set wins
    logic [2:0] irq_set;
    logic [2:0] irq_clr;
    assign irq_set = {w95_set, a34_set && !alm34_ff, a38_set && !alm38_ff};
    assign irq_clr = (wr_ff && addr_ff == `DLOP_IRQ_OFS) ? hwdata[2:0] : 3'h0;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_ff <= 3'h0;
            mask_ff <= 3'h0;
            irq <= 1'b0;
        end
        else
        begin
            irq_ff <= irq_set | (irq_ff & ~irq_clr);
            if (wr_ff && addr_ff == `DLOP_MASK_OFS)
                mask_ff <= hwdata[2:0];
            irq <= |(irq_ff & mask_ff);
        end
    end

    // drive outputs
    dlop_decel_type alm_decel;
    assign alm_decel = alm_sel == 2'd0 ? DLOP_DM_DBRAKE
        : alm_sel == 2'd1 ? DLOP_DM_FREE : DLOP_DM_ESTOP;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            drive <= '0;
            torque_limit <= 10'h000;
            alarm_stop <= 1'b0;
            mon_fwd <= 1'b0;
            mon_rev <= 1'b0;
        end
        else
        begin
            alarm_stop <= alarm_any;
            drive.fwd_block <= fwd_act;
            drive.rev_block <= rev_act;
            drive.err_clear <= err_clear;
            drive.err_hold <= (phase_ff == DLOP_DECEL && stop_sel == 2'd2)
                || (phase_ff == DLOP_STOPPED && !estop_done_clear);
            drive.zero_fwd_trq <= phase_ff == DLOP_STOPPED && stop_sel != 2'd2 && fwd_act;
            drive.zero_rev_trq <= phase_ff == DLOP_STOPPED && stop_sel != 2'd2 && rev_act;
            if (alarm_any)
                drive.decel <= alm_decel;
            else if (phase_ff == DLOP_DECEL)
                drive.decel <= stop_sel == 2'd0 ? DLOP_DM_DBRAKE
                    : stop_sel == 2'd1 ? DLOP_DM_FREE : DLOP_DM_ESTOP;
            else
                drive.decel <= DLOP_DM_NONE;
            if (phase_ff == DLOP_DECEL && stop_sel == 2'd2 && etq_ff != 10'h000)
                torque_limit <= etq_ff;
            else
                torque_limit <= norm_tlim_ff;
            mon_fwd <= lim_sel == 2'd1 ? (limsel_ff[`DLOP_MON_SEL] && fwd_open) : fwd_open;
            mon_rev <= lim_sel == 2'd1 ? (limsel_ff[`DLOP_MON_SEL] && rev_open) : rev_open;
        end
    end

    // read mux, zero-wait data phase
    logic [31:0] rmux;
    always_comb
    begin
        unique case (haddr[7:0])
            `DLOP_CTRL_OFS: rmux = {24'h0, ctrl_ff};
            `DLOP_LIMSEL_OFS: rmux = {24'h0, limsel_ff};
            `DLOP_ETQ_OFS: rmux = {22'h0, etq_ff};
            `DLOP_OVR_OFS: rmux = ovr_ff;
            `DLOP_CMD_OFS: rmux = cmd_ff;
            `DLOP_MPOS_OFS: rmux = mpos_ff;
            `DLOP_SPEED_OFS: rmux = {16'h0, speed_ff};
            `DLOP_STAT_OFS: rmux = {26'h0, alm34_ff, alm38_ff, phase_ff, rev_open, fwd_open};
            `DLOP_IRQ_OFS: rmux = {29'h0, irq_ff};
            `DLOP_MASK_OFS: rmux = {29'h0, mask_ff};
            `DLOP_OUT_OFS: rmux = {22'h0, norm_tlim_ff};
            `DLOP_RANGE_LO_OFS: rmux = lo_ff;
            `DLOP_RANGE_HI_OFS: rmux = hi_ff;
            default: rmux = 32'h0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (acc && !hwrite)
                hrdata <= rmux;
        end
    end

endmodule : dlop_limit_overrun
`default_nettype wire

// file: dlop_limit_overrun_chk.sv
`timescale 1ns/1ps
`default_nettype none

module dlop_limit_overrun_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic forward_limit_input,
    input wire logic reverse_limit_input,
    input wire dlop_pkg::dlop_drive_type drive,
    input wire logic [9:0] torque_limit,
    input wire logic alarm_stop,
    input wire logic mon_fwd,
    input wire logic mon_rev
);
    import dlop_pkg::*;
    logic [3:0] wr_age_ff;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // cycles since the last write was taken, saturating
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            wr_age_ff <= 4'hf;
        else if (hsel && hready && htrans[1] && hwrite)
            wr_age_ff <= 4'h0;
        else if (wr_age_ff != 4'hf)
            wr_age_ff <= wr_age_ff + 4'h1;
    end

    AST_FWD_BLOCK: assert property (drive.fwd_block |->
        !$past(forward_limit_input, 3) || !$past(forward_limit_input, 4))
        else $error("forward blocked with forward limit shorted");
    AST_REV_BLOCK: assert property (drive.rev_block |->
        !$past(reverse_limit_input, 3) || !$past(reverse_limit_input, 4))
        else $error("reverse blocked with reverse limit shorted");
    AST_MON_FWD: assert property (mon_fwd |->
        !$past(forward_limit_input, 3) || !$past(forward_limit_input, 4))
        else $error("forward monitor set with limit shorted");
    AST_MON_REV: assert property (mon_rev |->
        !$past(reverse_limit_input, 3) || !$past(reverse_limit_input, 4))
        else $error("reverse monitor set with limit shorted");
    AST_BRAKE_CLEAR: assert property ((drive.decel == DLOP_DM_DBRAKE ||
        drive.decel == DLOP_DM_FREE) && !alarm_stop |-> drive.err_clear && !drive.err_hold)
        else $error("braking stop without counter clear");
    AST_ESTOP_HOLD: assert property ((drive.decel == DLOP_DM_ESTOP) && !alarm_stop |->
        drive.err_hold)
        else $error("controlled stop without counter hold");
    AST_ESTOP_TRQ: assert property ((drive.decel == DLOP_DM_ESTOP) |->
        torque_limit <= 10'd500)
        else $error("stop torque limit above 500");
    AST_ZERO_HOLD: assert property ((drive.zero_fwd_trq || drive.zero_rev_trq) |->
        drive.err_hold && (alarm_stop || drive.decel == DLOP_DM_NONE))
        else $error("zero torque after stop without hold");
    AST_ALM_LATCH: assert property ($fell(alarm_stop) |-> wr_age_ff <= 4'd6)
        else $error("alarm dropped without a reset write");
endmodule : dlop_limit_overrun_chk

bind dlop_limit_overrun dlop_limit_overrun_chk i_chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .forward_limit_input(forward_limit_input), .reverse_limit_input(reverse_limit_input),
    .drive(drive), .torque_limit(torque_limit), .alarm_stop(alarm_stop),
    .mon_fwd(mon_fwd), .mon_rev(mon_rev));

`default_nettype wire

// file: dlop_map.svh
`ifndef DLOP_MAP_SVH
`define DLOP_MAP_SVH

// register byte offsets
`define DLOP_CTRL_OFS        8'h00
`define DLOP_LIMSEL_OFS      8'h04
`define DLOP_ETQ_OFS         8'h08
`define DLOP_OVR_OFS         8'h0c
`define DLOP_CMD_OFS         8'h10
`define DLOP_MPOS_OFS        8'h14
`define DLOP_SPEED_OFS       8'h18
`define DLOP_STAT_OFS        8'h1c
`define DLOP_IRQ_OFS         8'h20
`define DLOP_MASK_OFS        8'h24
`define DLOP_OUT_OFS         8'h28
`define DLOP_RANGE_LO_OFS    8'h2c
`define DLOP_RANGE_HI_OFS    8'h30

// ctrl fields
`define DLOP_CTRL_SERVO_ON   0
`define DLOP_CTRL_MODE_LO    1
`define DLOP_CTRL_FREQ_CHAR  3
`define DLOP_CTRL_POS_INIT   4
`define DLOP_CTRL_TRIAL      5
`define DLOP_CTRL_ERR_CLR    6
`define DLOP_CTRL_ALM_RST    7

// limsel fields
`define DLOP_LIM_SEL_LO      0
`define DLOP_STOP_SEL_LO     2
`define DLOP_ALM_STOP_LO     4
`define DLOP_MON_SEL         6

// irq bits
`define DLOP_IRQ_A38         0
`define DLOP_IRQ_A34         1
`define DLOP_IRQ_W95         2

// reset values
`define DLOP_LIMSEL_RST      8'h01
`define DLOP_ETQ_RST         10'h000
`define DLOP_OVR_RST         32'h0000000a
`define DLOP_TLIM_RST        10'h12c

// motor stopped threshold, r/min
`define DLOP_STOP_SPEED      16'd30
`define DLOP_ETQ_MAX         10'd500

`endif

// file: dlop_pkg.sv
package dlop_pkg;

    typedef enum logic [1:0] {
        DLOP_MODE_POS = 2'b00,
        DLOP_MODE_SPD = 2'b01,
        DLOP_MODE_TRQ = 2'b10,
        DLOP_MODE_FULL = 2'b11
    } dlop_mode_type;

    typedef enum logic [1:0] {
        DLOP_RUN = 2'b00,
        DLOP_DECEL = 2'b01,
        DLOP_STOPPED = 2'b10
    } dlop_phase_type;

    typedef enum logic [1:0] {
        DLOP_DM_NONE = 2'b00,
        DLOP_DM_DBRAKE = 2'b01,
        DLOP_DM_FREE = 2'b10,
        DLOP_DM_ESTOP = 2'b11
    } dlop_decel_type;

    typedef struct packed {
        logic fwd_block;
        logic rev_block;
        logic err_clear;
        logic err_hold;
        logic zero_fwd_trq;
        logic zero_rev_trq;
        dlop_decel_type decel;
    } dlop_drive_type;

    typedef struct packed {
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hsel;
    } dlop_ahb_req_type;

endpackage : dlop_pkg

// file: dlop_switch_model.sv
`timescale 1ns/1ps
`default_nettype none

// limit switch pair: 1 = contact shorted (normal), 0 = open (limit reached)
module dlop_switch_model (
    input wire logic hclk,
    input wire logic fwd_open,
    input wire logic rev_open,
    output logic forward_limit_input,
    output logic reverse_limit_input
);
    initial
    begin
        forward_limit_input = 1'b1;
        reverse_limit_input = 1'b1;
    end

    // contacts change just after an edge, like any other driven input
    always @(posedge hclk)
    begin
        forward_limit_input <= ~fwd_open;
        reverse_limit_input <= ~rev_open;
    end
endmodule : dlop_switch_model

`default_nettype wire

// file: tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "dlop_map.svh"

module tb;
    import dlop_pkg::*;
    logic hclk, hresetn, hsel, hwrite, fwd_open, rev_open, fwd_in, rev_in;
    logic hreadyout, hresp, alarm_stop, mon_fwd, mon_rev, irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [9:0] torque_limit;
    dlop_drive_type drv;
    int failures, n_checks, cycles, etq, c1, c2, s;

    dlop_limit_overrun i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .forward_limit_input(fwd_in),
        .reverse_limit_input(rev_in), .drive(drv), .torque_limit(torque_limit),
        .alarm_stop(alarm_stop), .mon_fwd(mon_fwd), .mon_rev(mon_rev), .irq(irq));
    dlop_switch_model i_sw (.hclk(hclk), .fwd_open(fwd_open), .rev_open(rev_open),
        .forward_limit_input(fwd_in), .reverse_limit_input(rev_in));

    initial
    begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    task automatic wrap_up();
        if (failures == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up

    always @(posedge hclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            failures++;
            wrap_up();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask : cyc

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic chkb(input logic seen, input logic exp);
        chk({31'h0, seen}, {31'h0, exp});
    endtask : chkb

    // one single transfer; read data taken at the edge ending the data phase
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : xfer

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        xfer(1'b1, a, d, dummy);
    endtask : wr

    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] v;
        cyc(2);
        xfer(1'b0, a, 32'h0, v);
        chk(v, exp);
    endtask : rdchk

    function automatic logic [31:0] exp_etq(input int v);
        return (v > 500) ? 32'd500 : 32'(v);
    endfunction : exp_etq

    function automatic logic [31:0] edge_of(input int pos, input int ovr, input int cmd);
        return 32'(pos + ovr + cmd);
    endfunction : edge_of

    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        fwd_open = 1'b0;
        rev_open = 1'b0;
        failures = 0;
        n_checks = 0;
        cycles = 0;
        void'($urandom(58959));
        cyc(10);
        hresetn <= 1'b1;
        cyc(1);
        rdchk(`DLOP_LIMSEL_OFS, 32'h1);
        chkb(hresp, 1'b0);
        rdchk(`DLOP_OVR_OFS, 32'ha);
        rdchk(`DLOP_ETQ_OFS, 32'h0);
        rdchk(`DLOP_OUT_OFS, 32'h12c);
        rdchk(32'h3c, 32'h0);
        fwd_open <= 1'b1;
        cyc(6);
        chkb(drv.fwd_block, 1'b0);
        chkb(alarm_stop, 1'b0);
        chkb(mon_fwd, 1'b0);
        wr(`DLOP_LIMSEL_OFS, 32'h41);
        cyc(4);
        chkb(mon_fwd, 1'b1);
        fwd_open <= 1'b0;
        wr(`DLOP_SPEED_OFS, 32'd100);
        for (s = 0; s < 2; s++)
        begin
            wr(`DLOP_LIMSEL_OFS, 32'(s << 2));
            fwd_open <= 1'b1;
            cyc(6);
            chk({30'h0, drv.decel}, {30'h0, (s == 1) ? DLOP_DM_FREE : DLOP_DM_DBRAKE});
            chkb(drv.err_clear, 1'b1);
            chkb(drv.fwd_block, 1'b1);
            chkb(drv.rev_block, 1'b0);
            wr(`DLOP_SPEED_OFS, 32'd20);
            cyc(4);
            chkb(drv.zero_fwd_trq, 1'b1);
            chkb(drv.err_hold, 1'b1);
            wr(`DLOP_SPEED_OFS, 32'd100);
            cyc(4);
            chkb(drv.zero_fwd_trq, 1'b1);
            fwd_open <= 1'b0;
            cyc(6);
        end
        wr(`DLOP_IRQ_OFS, 32'h7);
        wr(`DLOP_SPEED_OFS, 32'd20);
        fwd_open <= 1'b1;
        cyc(6);
        wr(`DLOP_CMD_OFS, 32'hfffffffb);
        rdchk(`DLOP_IRQ_OFS, 32'h0);
        wr(`DLOP_CMD_OFS, 32'h5);
        rdchk(`DLOP_IRQ_OFS, 32'h4);
        fwd_open <= 1'b0;
        cyc(6);
        wr(`DLOP_IRQ_OFS, 32'h7);
        etq = $urandom_range(500, 1);
        wr(`DLOP_ETQ_OFS, 32'(etq));
        wr(`DLOP_LIMSEL_OFS, 32'h08);
        wr(`DLOP_SPEED_OFS, 32'd100);
        rev_open <= 1'b1;
        cyc(6);
        chk({30'h0, drv.decel}, {30'h0, DLOP_DM_ESTOP});
        chkb(drv.err_hold, 1'b1);
        chk({22'h0, torque_limit}, exp_etq(etq));
        chkb(drv.rev_block, 1'b1);
        chkb(drv.fwd_block, 1'b0);
        wr(`DLOP_ETQ_OFS, 32'h0);
        cyc(4);
        chk({22'h0, torque_limit}, 32'h12c);
        wr(`DLOP_SPEED_OFS, 32'd20);
        cyc(4);
        chkb(drv.zero_rev_trq, 1'b0);
        chkb(drv.err_hold, 1'b1);
        rev_open <= 1'b0;
        wr(`DLOP_ETQ_OFS, 32'd600);
        rdchk(`DLOP_ETQ_OFS, exp_etq(600));
        wr(`DLOP_MASK_OFS, 32'h0);
        wr(`DLOP_LIMSEL_OFS, 32'h0);
        fwd_open <= 1'b1;
        rev_open <= 1'b1;
        cyc(6);
        chkb(alarm_stop, 1'b1);
        rdchk(`DLOP_IRQ_OFS, 32'h1);
        chkb(irq, 1'b0);
        wr(`DLOP_MASK_OFS, 32'h1);
        cyc(3);
        chkb(irq, 1'b1);
        wr(`DLOP_IRQ_OFS, 32'h1);
        cyc(3);
        chkb(irq, 1'b0);
        fwd_open <= 1'b0;
        rev_open <= 1'b0;
        cyc(4);
        wr(`DLOP_CTRL_OFS, 32'h80);
        cyc(4);
        chkb(alarm_stop, 1'b0);
        wr(`DLOP_LIMSEL_OFS, 32'h2);
        rev_open <= 1'b1;
        cyc(6);
        chkb(alarm_stop, 1'b1);
        chkb(mon_rev, 1'b1);
        rev_open <= 1'b0;
        cyc(4);
        wr(`DLOP_CTRL_OFS, 32'h80);
        cyc(4);
        chkb(alarm_stop, 1'b0);
        wr(`DLOP_LIMSEL_OFS, 32'h11);
        wr(`DLOP_MPOS_OFS, 32'h0);
        wr(`DLOP_SPEED_OFS, 32'd100);
        wr(`DLOP_CTRL_OFS, 32'h1);
        rdchk(`DLOP_RANGE_LO_OFS, edge_of(0, -10, 0));
        rdchk(`DLOP_RANGE_HI_OFS, edge_of(0, 10, 0));
        c1 = $urandom_range(100, 1);
        c2 = c1 + $urandom_range(100, 1);
        wr(`DLOP_CMD_OFS, 32'(c1));
        wr(`DLOP_CMD_OFS, 32'(-c2));
        rdchk(`DLOP_RANGE_HI_OFS, edge_of(0, 10, c1));
        rdchk(`DLOP_RANGE_LO_OFS, edge_of(0, -10, c1 - c2));
        wr(`DLOP_MPOS_OFS, edge_of(0, 10, c1));
        cyc(4);
        chkb(alarm_stop, 1'b0);
        wr(`DLOP_MPOS_OFS, edge_of(0, 11, c1));
        cyc(4);
        chkb(alarm_stop, 1'b1);
        chk({30'h0, drv.decel}, {30'h0, DLOP_DM_FREE});
        wr(`DLOP_MPOS_OFS, 32'h0);
        wr(`DLOP_CTRL_OFS, 32'h80);
        wr(`DLOP_CTRL_OFS, 32'h09);
        wr(`DLOP_MPOS_OFS, 32'h1000);
        cyc(4);
        chkb(alarm_stop, 1'b0);
        wr(`DLOP_CTRL_OFS, 32'h03);
        cyc(4);
        chkb(alarm_stop, 1'b0);
        rdchk(`DLOP_RANGE_HI_OFS, edge_of(32'h1000, 10, 0));
        wr(`DLOP_CTRL_OFS, 32'h0);
        wr(`DLOP_MPOS_OFS, 32'h20);
        rdchk(`DLOP_RANGE_LO_OFS, edge_of(32'h20, -10, 0));
        wrap_up();
    end
endmodule : tb

`default_nettype wire
